//--- bench/pvp_checker.sv
// port-level assertions for the post-processing block
`timescale 1ns/10ps
module pvp_checker (
  input wire logic               core_clk_i,
  input wire logic               rst_n_i,
  input wire logic               meas_valid_i,
  input wire logic               od_wr_i,
  input wire logic               od_rd_i,
  input wire logic [15:0]        od_index_i,
  input wire logic [7:0]         od_sub_i,
  input wire logic [31:0]        od_wdata_i,
  input wire logic               od_ack_o,
  input wire logic               od_err_o,
  input wire logic [31:0]        od_rdata_o,
  input wire logic signed [31:0] pos_o,
  input wire logic               pos_valid_o,
  input wire logic signed [31:0] vel_o,
  input wire logic               vel_valid_o,
  input wire logic [1:0]         range_out_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ack; (od_wr_i || od_rd_i) |=> od_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("request without answer");
  property p_idle; !(od_wr_i || od_rd_i) |=> !od_ack_o && od_rdata_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_ro; od_wr_i && od_index_i == 16'h2020 && od_sub_i == 8'h04 |=> od_err_o; endproperty
  a_ro: assert property (p_ro) else $error("velocity readout accepted a write");
  property p_cmd; od_wr_i && od_index_i inside {16'h2001, 16'h2002} && od_sub_i == 8'h02 && od_wdata_i > 32'h2 |=> od_err_o; endproperty
  a_cmd: assert property (p_cmd) else $error("bad preset code accepted");
  property p_en; od_wr_i && od_index_i inside {16'h2010, 16'h2011} && od_sub_i == 8'h01 && od_wdata_i > 32'h1 |=> od_err_o; endproperty
  a_en: assert property (p_en) else $error("bad range enable accepted");
  property p_pv; pos_valid_o == $past(meas_valid_i); endproperty
  a_pv: assert property (p_pv) else $error("position strobe not one cycle after sample");
  property p_pclamp; pos_valid_o |-> pos_o >= pvp_pkg::POS_MIN && pos_o <= pvp_pkg::POS_MAX; endproperty
  a_pclamp: assert property (p_pclamp) else $error("position out of range");
  property p_hold; !pos_valid_o |-> $stable(pos_o) && $stable(range_out_o); endproperty
  a_hold: assert property (p_hold) else $error("position or range flags moved between samples");
  property p_vhold; !vel_valid_o |-> $stable(vel_o); endproperty
  a_vhold: assert property (p_vhold) else $error("velocity moved inside a window");
endmodule : pvp_checker

//--- bench/pvp_master.sv
// far-side object-bus master model
`timescale 1ns/10ps
module pvp_master (
  input  wire logic   core_clk_i,
  output logic        od_wr_o,
  output logic        od_rd_o,
  output logic [15:0] od_index_o,
  output logic [7:0]  od_sub_o,
  output logic [31:0] od_wdata_o
);
  initial {od_wr_o, od_rd_o, od_index_o, od_sub_o, od_wdata_o} = '0;
  // one-cycle request pulse; commands and dynamic preset may come at any time
  task automatic xfer(input logic wr, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d);
    @(negedge core_clk_i);
    od_wr_o = wr;
    od_rd_o = !wr;
    od_index_o = ix;
    od_sub_o = sb;
    od_wdata_o = d;
    @(negedge core_clk_i);
    od_wr_o = 1'b0;
    od_rd_o = 1'b0;
    // released data must not look like the last word
    od_wdata_o = ~d;
  endtask : xfer
endmodule : pvp_master

//--- bench/tb_top.sv
// self-checking bench for the post-processing block
`timescale 1ns/10ps
module tb_top;
  logic               core_clk_i   = 1'b0;
  logic               rst_n_i      = 1'b0;
  logic               meas_valid_i = 1'b0;
  logic signed [31:0] meas_pos_i   = 32'sh0;
  logic signed [31:0] meas_vel_i   = 32'sh0;
  logic               od_wr_i, od_rd_i, od_ack_o, od_err_o, pos_valid_o, vel_valid_o;
  logic [15:0]        od_index_i;
  logic [7:0]         od_sub_i;
  logic [31:0]        od_wdata_i, od_rdata_o;
  logic signed [31:0] pos_o, vel_o;
  logic [1:0]         range_out_o;
  logic [3:0]         vmon_o;
  logic [33:0]        q_od[$], q_pos[$], q_vel[$];
  int                 error_cnt = 0, tests_run = 0, off, p;
  int                 dv[5] = '{1000, 10000, 100000, 1000000, 500};
  pvp_master m_u (.core_clk_i, .od_wr_o(od_wr_i), .od_rd_o(od_rd_i), .od_index_o(od_index_i), .od_sub_o(od_sub_i),
    .od_wdata_o(od_wdata_i));
  pvp_postproc #(.WIN_BASE_CYC(8)) dut_u (.core_clk_i, .rst_n_i, .meas_valid_i, .meas_pos_i, .meas_vel_i, .od_wr_i,
    .od_rd_i, .od_index_i, .od_sub_i, .od_wdata_i, .od_ack_o, .od_err_o, .od_rdata_o, .pos_o, .pos_valid_o, .vel_o,
    .vel_valid_o, .range_out_o, .vmon_o);
  initial forever #20 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    if (q_od.size() + q_pos.size() + q_vel.size() > 0) error_cnt++;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  task automatic od(input logic wr, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d,
                    input logic er, input logic [31:0] rd);
    q_od.push_back({1'b0, er, rd});
    m_u.xfer(wr, ix, sb, d);
  endtask : od
  task automatic meas(input logic signed [31:0] ps, input logic signed [31:0] e, input logic [1:0] r);
    @(negedge core_clk_i);
    meas_pos_i = ps;
    meas_valid_i = 1'b1;
    q_pos.push_back({r, e});
    @(negedge core_clk_i);
    meas_valid_i = 1'b0;
  endtask : meas
  // alternating samples, so every full window averages to 1235567
  task automatic vel_run(input logic signed [31:0] e);
    int n;
    n = 0;
    meas_valid_i = 1'b1;
    for (int t = 0; t < 200 && n < 3; t++) begin
      @(negedge core_clk_i);
      meas_vel_i = (t % 2) ? 32'sd1236567 : 32'sd1234567;
      if (vel_valid_o) n++;
      if (n == 2 && !vel_valid_o && q_vel.size() == 0) q_vel.push_back({2'b00, e});
    end
    meas_valid_i = 1'b0;
    if (n < 3) begin
      error_cnt++;
      end_of_test();
    end
  endtask : vel_run
  always @(negedge core_clk_i) begin
    if (od_ack_o && q_od.size() > 0) chk({1'b0, od_err_o, od_rdata_o}, q_od.pop_front());
    if (pos_valid_o && q_pos.size() > 0) chk({range_out_o, pos_o}, q_pos.pop_front());
    if (vel_valid_o && q_vel.size() > 0) chk({2'b00, vel_o}, q_vel.pop_front());
  end
  initial begin
    void'($urandom(11));
    repeat (20) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    od(0, 16'h2020, 8'h01, 0, 0, 1);
    od(0, 16'h2020, 8'h02, 0, 0, 3);
    od(0, 16'h2020, 8'h03, 0, 0, 32'h3e8);
    od(0, 16'h2001, 8'h01, 0, 0, 0);
    od(0, 16'h2010, 8'h01, 0, 0, 0);
    od(0, 16'h2030, 8'h01, 0, 1, 0);
    od(1, 16'h2020, 8'h04, 5, 1, 0);
    od(1, 16'h2020, 8'h03, 50001, 1, 0);
    p = $urandom_range(99999, 0);
    off = $urandom_range(999, 1);
    for (int s = -1; s < 2; s += 2) begin
      od(1, 16'h2000, 8'h05, s * off, 0, 0);
      meas(p, (p + s * off * 1000) / 1000, 2'b00);
    end
    od(1, 16'h2000, 8'h06, 500, 0, 0);
    od(1, 16'h2000, 8'h06, 4, 1, 0);
    od(1, 16'h2000, 8'h03, 6, 0, 0);
    meas(p, (p + off * 1000) / 500, 2'b00);
    od(1, 16'h2000, 8'h03, 3, 0, 0);
    meas(p, (p + off * 1000) / 100, 2'b00);
    od(1, 16'h2000, 8'h03, 4, 0, 0);
    for (int k = 0; k < 2; k++) begin
      od(1, 16'h2001 + k, 8'h01, 250, 0, 0);
      meas_pos_i = p;
      od(1, 16'h2001 + k, 8'h02, 1, 0, 0);
      meas(p + 3000, 253, 2'b00);
      od(1, 16'h2001 + k, 8'h02, 3, 1, 0);
      od(0, 16'h2001 + k, 8'h02, 0, 0, 1);
      od(1, 16'h2001 + k, 8'h02, 2, 0, 0);
      meas(p, (p + off * 1000) / 1000, 2'b00);
    end
    od(1, 16'h2002, 8'h01, 7, 0, 0);
    od(0, 16'h2001, 8'h01, 0, 0, 250);
    od(1, 16'h2000, 8'h05, 0, 0, 0);
    od(1, 16'h2010, 8'h02, 30, 0, 0);
    od(1, 16'h2010, 8'h03, 40, 0, 0);
    od(1, 16'h2010, 8'h01, 1, 0, 0);
    od(1, 16'h2011, 8'h01, 2, 1, 0);
    meas(25000, 25, 2'b01);
    meas(40999, 40, 2'b00);
    meas(41000, 41, 2'b01);
    od(1, 16'h2020, 8'h02, 0, 0, 0);
    od(1, 16'h2020, 8'h03, 500, 0, 0);
    od(1, 16'h2021, 8'h02, 1000, 0, 0);
    od(1, 16'h2021, 8'h01, 4, 0, 0);
    for (int c = 1; c < 6; c++) begin
      od(1, 16'h2020, 8'h01, c, 0, 0);
      od(1, 16'h2000, 8'h04, c % 2, 0, 0);
      vel_run(((c % 2) ? -1235567 : 1235567) / dv[c - 1]);
    end
    // magnitude 1235 over limit 1000 until the next empty window
    repeat (2) @(negedge core_clk_i);
    chk(vmon_o, 1);
    end_of_test();
  end
endmodule : tb_top
bind pvp_postproc pvp_checker chk_u (.core_clk_i, .rst_n_i, .meas_valid_i, .od_wr_i, .od_rd_i, .od_index_i,
  .od_sub_i, .od_wdata_i, .od_ack_o, .od_err_o, .od_rdata_o, .pos_o, .pos_valid_o, .vel_o, .vel_valid_o, .range_out_o);

//--- verilog/pvp_pkg.sv
// constants for the position and velocity post-processing block
package pvp_pkg;
  // object dictionary indices
  localparam logic [15:0] OD_POS    = 16'h2000;
  localparam logic [15:0] OD_SPRE   = 16'h2001;
  localparam logic [15:0] OD_DPRE   = 16'h2002;
  localparam logic [15:0] OD_RNG1   = 16'h2010;
  localparam logic [15:0] OD_RNG2   = 16'h2011;
  localparam logic [15:0] OD_VEL    = 16'h2020;
  localparam logic [15:0] OD_VMON1  = 16'h2021;
  localparam logic [15:0] OD_VMON4  = 16'h2024;
  // sub-indices
  localparam logic [7:0] SUB_UNIT   = 8'h02;
  localparam logic [7:0] SUB_RES    = 8'h03;
  localparam logic [7:0] SUB_DIR    = 8'h04;
  localparam logic [7:0] SUB_OFFS   = 8'h05;
  localparam logic [7:0] SUB_FREE   = 8'h06;
  localparam logic [7:0] SUB_PVAL   = 8'h01;
  localparam logic [7:0] SUB_PCMD   = 8'h02;
  localparam logic [7:0] SUB_REN    = 8'h01;
  localparam logic [7:0] SUB_RLO    = 8'h02;
  localparam logic [7:0] SUB_RHI    = 8'h03;
  localparam logic [7:0] SUB_VRES   = 8'h01;
  localparam logic [7:0] SUB_VWIN   = 8'h02;
  localparam logic [7:0] SUB_VFREE  = 8'h03;
  localparam logic [7:0] SUB_VVAL   = 8'h04;
  localparam logic [7:0] SUB_VCFG   = 8'h01;
  localparam logic [7:0] SUB_VLIM   = 8'h02;
  // value ranges
  localparam logic signed [31:0] POS_MAX  = 32'sh000f423f;
  localparam logic signed [31:0] POS_MIN  = -32'sh000f423f;
  localparam logic [31:0] FREE_MIN        = 32'h00000005;
  localparam logic [31:0] FREE_MAX        = 32'h0000c350;
  localparam logic [31:0] RES_MAX         = 32'h00000006;
  localparam logic [31:0] VRES_MIN        = 32'h00000001;
  localparam logic [31:0] VRES_MAX        = 32'h00000005;
  localparam logic [31:0] VWIN_MAX        = 32'h00000006;
  localparam logic [31:0] PCMD_MAX        = 32'h00000002;
  localparam logic [31:0] VCFG_MAX        = 32'h00000007;
  localparam logic [31:0] VLIM_MAX        = 32'h00004e20;
  localparam logic [31:0] BIT_MAX         = 32'h00000001;
  // reset values
  localparam logic [2:0]  RES_RST   = 3'h4;
  localparam logic [2:0]  VRES_RST  = 3'h1;
  localparam logic [2:0]  VWIN_RST  = 3'h3;
  localparam logic [15:0] FREE_RST  = 16'h03e8;
  // preset commands
  localparam logic [7:0] PCMD_TEACH = 8'h01;
  localparam logic [7:0] PCMD_RESET = 8'h02;
  // fine raw units per base unit (um per mm, 1e-5 in per 0.01 in)
  localparam logic signed [47:0] BASE_DIV = 48'sh0000000003e8;
  // velocity monitoring config bits and channel count
  localparam int VCFG_MODE = 0;
  localparam int VCFG_EN   = 2;
  localparam int VMON_CH   = 4;
  // timing
  localparam int CLK_HZ       = 25000000;
  localparam int VWIN_BASE_MS = 2;
  localparam int VWIN_BASE_CYC = CLK_HZ / 1000 * VWIN_BASE_MS;
endpackage : pvp_pkg

//--- verilog/pvp_postproc.sv
// position offset/preset/scaling, limit ranges and velocity averaging
`timescale 1ns/10ps
// Function
// R1 - reported position is measured position plus signed offset in base unit
// R2 - an active taught preset replaces the offset correction
// R3 - preset and offset correction are never applied together
// R4 - offset is always in base units, whatever resolution is selected
// R5 - a written offset applies to the very next output position
// R6 - free resolution step is parameter times one micrometre or 1e-5 inch
// R7 - free factor only used when selector picks the free setting
// R8 - preset command field takes 0 to 2; 1 teaches, 2 resets
// R9 - after preset reset the uncorrected measured position is reported; the code still applies the offset correction
// R10 - static and dynamic presets kept independently, each with its command
// R11 - enabled range flags status when position lies outside its window
// R12 - two ranges, each with enable bit and signed lower and upper limit
// R13 - limit values are in base units of the selected unit
// R14 - velocity uses position unit, metric by default
// R15 - default direction: moving away positive, approaching negative
// R16 - negative count direction inverts every reported velocity
// R17 - velocity is mean of samples over window 2 to 128 ms, default 16
// R18 - velocity scale codes 1 to 5: 1, 10, 100, 1000, free; default 1
// R19 - free velocity step is parameter 5..50000 times 1 um/s, default 1000
// R20 - velocity readout is read-only signed 32 bit clamped to 999999
// R21 - four velocity monitors compare velocity to their own limits
// R22 - teach latches correction so output equals preset, held until reset
// R23 - out-of-range parameter writes are refused, old value kept
module pvp_postproc #(
  parameter int WIN_BASE_CYC = pvp_pkg::VWIN_BASE_CYC
) (
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               meas_valid_i,
  input  wire logic signed [31:0] meas_pos_i,
  input  wire logic signed [31:0] meas_vel_i,
  input  wire logic               od_wr_i,
  input  wire logic               od_rd_i,
  input  wire logic [15:0]        od_index_i,
  input  wire logic [7:0]         od_sub_i,
  input  wire logic [31:0]        od_wdata_i,
  output logic                    od_ack_o,
  output logic                    od_err_o,
  output logic [31:0]             od_rdata_o,
  output logic signed [31:0]      pos_o,
  output logic                    pos_valid_o,
  output logic signed [31:0]      vel_o,
  output logic                    vel_valid_o,
  output logic [1:0]              range_out_o,
  output logic [3:0]              vmon_o
);

  // divisor from fine raw units to the selected position resolution
  function automatic logic signed [47:0] pos_div(input logic [2:0] code, input logic [15:0] free);
    case (code)
      3'h1:    pos_div = 48'sh000000000001;
      3'h2:    pos_div = 48'sh00000000000a;
      3'h3:    pos_div = 48'sh000000000064;
      3'h5:    pos_div = 48'sh000000002710;
      3'h6:    pos_div = $signed({32'h0, free});
      default: pos_div = 48'sh0000000003e8;
    endcase
  endfunction : pos_div

  // divisor from fine raw velocity to the selected velocity resolution
  function automatic logic signed [47:0] vel_div(input logic [2:0] code, input logic [15:0] free);
    case (code)
      3'h2:    vel_div = 48'sh000000002710;
      3'h3:    vel_div = 48'sh0000000186a0;
      3'h4:    vel_div = 48'sh0000000f4240;
      3'h5:    vel_div = $signed({32'h0, free});
      default: vel_div = 48'sh0000000003e8;
    endcase
  endfunction : vel_div

  function automatic logic signed [31:0] clamp(input logic signed [47:0] v);
    if (v > 48'(pvp_pkg::POS_MAX)) begin
      clamp = pvp_pkg::POS_MAX;
    end else if (v < 48'(pvp_pkg::POS_MIN)) begin
      clamp = pvp_pkg::POS_MIN;
    end else begin
      clamp = v[31:0];
    end
  endfunction : clamp

  function automatic logic in_urange(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    in_urange = (v >= lo) && (v <= hi);
  endfunction : in_urange

  // parameter registers
  logic                    unit_inch;
  logic [2:0]              pos_res;
  logic                    dir_neg;
  logic signed [31:0]      offset;
  logic [15:0]             pos_free;
  logic signed [31:0]      pre_val   [2];
  logic [7:0]              pre_cmd   [2];
  logic                    pre_act   [2];
  logic signed [47:0]      pre_corr  [2];
  logic                    rng_en    [2];
  logic signed [31:0]      rng_lo    [2];
  logic signed [31:0]      rng_hi    [2];
  logic [2:0]              vel_res;
  logic [2:0]              vel_win;
  logic [15:0]             vel_free;
  logic [2:0]              vm_cfg    [pvp_pkg::VMON_CH];
  logic [15:0]             vm_lim    [pvp_pkg::VMON_CH];
  // velocity averaging state
  logic signed [47:0]      vsum;
  logic [23:0]             vcnt;
  logic [23:0]             vtimer;
  logic signed [47:0]      vmean_base;

  // position path: raw units are um (metric) or 1e-5 in (inch)
  logic signed [47:0]      meas_eff;
  logic signed [47:0]      off_raw;
  logic signed [47:0]      corr;
  logic signed [47:0]      pos_adj;
  logic signed [47:0]      pos_base;
  logic signed [47:0]      pos_scaled;
  logic [1:0]              rng_outside;

  assign meas_eff   = dir_neg ? -48'(meas_pos_i) : 48'(meas_pos_i);
  assign off_raw    = 48'(offset) * pvp_pkg::BASE_DIV;                          // R4
  // dynamic preset has priority over static; either replaces the offset
  assign corr       = pre_act[1] ? pre_corr[1] :                                // R2
                      pre_act[0] ? pre_corr[0] : off_raw;                       // R3
  assign pos_adj    = meas_eff + corr;                                          // R1
  assign pos_base   = pos_adj / pvp_pkg::BASE_DIV;                              // R13
  assign pos_scaled = pos_adj / pos_div(pos_res, pos_free);                     // R6 R7

  generate
    for (genvar r = 0; r < 2; r++) begin : g_rng
      assign rng_outside[r] = rng_en[r] &&                                      // R12
                              ((pos_base < 48'(rng_lo[r])) || (pos_base > 48'(rng_hi[r]))); // R11
    end
  endgenerate

  // velocity path
  logic [23:0]             win_len;
  logic                    win_end;
  logic signed [47:0]      vsamp;
  logic signed [47:0]      vmean;
  logic signed [47:0]      vsigned;
  logic signed [47:0]      vmag;

  assign win_len = 24'(WIN_BASE_CYC) << vel_win;                                // R17
  assign win_end = (vtimer == 24'h0);
  assign vsamp   = 48'(meas_vel_i);
  assign vmean   = (vcnt == 24'h0) ? 48'sh0 : vsum / $signed({24'h0, vcnt});    // R17
  assign vsigned = dir_neg ? -vmean : vmean;                                    // R15 R16
  assign vmag    = (vmean_base < 0) ? -vmean_base : vmean_base;

  generate
    for (genvar c = 0; c < pvp_pkg::VMON_CH; c++) begin : g_vmon
      logic over;
      assign over = vmag > 48'(vm_lim[c]);
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          vmon_o[c] <= 1'b0;
        end else begin
          vmon_o[c] <= vm_cfg[c][pvp_pkg::VCFG_EN] &&                           // R21
                       (vm_cfg[c][pvp_pkg::VCFG_MODE] ? !over : over);
        end
      end
    end
  endgenerate

  // object dictionary decode
  logic        hit_pos;
  logic        hit_pre;
  logic        hit_rng;
  logic        hit_vel;
  logic        hit_vm;
  logic        psel;
  logic [1:0]  vsel;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic        wr_ok;

  assign hit_pos = (od_index_i == pvp_pkg::OD_POS);
  assign hit_pre = (od_index_i == pvp_pkg::OD_SPRE) || (od_index_i == pvp_pkg::OD_DPRE);
  assign hit_rng = (od_index_i == pvp_pkg::OD_RNG1) || (od_index_i == pvp_pkg::OD_RNG2);
  assign hit_vel = (od_index_i == pvp_pkg::OD_VEL);
  assign hit_vm  = (od_index_i >= pvp_pkg::OD_VMON1) && (od_index_i <= pvp_pkg::OD_VMON4);
  assign psel    = od_index_i[1];                                               // R10
  assign vsel    = 2'(od_index_i - pvp_pkg::OD_VMON1);

  always_comb begin
    rd_val = 32'h0;
    rd_ok  = 1'b0;
    wr_ok  = 1'b0;
    if (hit_pos) begin
      case (od_sub_i)
        pvp_pkg::SUB_UNIT: begin
          rd_val = {31'h0, unit_inch};
          rd_ok  = 1'b1;
          wr_ok  = in_urange(od_wdata_i, 32'h0, pvp_pkg::BIT_MAX);
        end
        pvp_pkg::SUB_RES: begin
          rd_val = {29'h0, pos_res};
          rd_ok  = 1'b1;
          wr_ok  = in_urange(od_wdata_i, 32'h0, pvp_pkg::RES_MAX);
        end
        pvp_pkg::SUB_DIR: begin
          rd_val = {31'h0, dir_neg};
          rd_ok  = 1'b1;
          wr_ok  = in_urange(od_wdata_i, 32'h0, pvp_pkg::BIT_MAX);
        end
        pvp_pkg::SUB_OFFS: begin
          rd_val = offset;
          rd_ok  = 1'b1;
          wr_ok  = ($signed(od_wdata_i) >= pvp_pkg::POS_MIN) && ($signed(od_wdata_i) <= pvp_pkg::POS_MAX);
        end
        pvp_pkg::SUB_FREE: begin
          rd_val = {16'h0, pos_free};
          rd_ok  = 1'b1;
          wr_ok  = in_urange(od_wdata_i, pvp_pkg::FREE_MIN, pvp_pkg::FREE_MAX);
        end
        default: rd_ok = 1'b0;
      endcase
    end else if (hit_pre) begin
      case (od_sub_i)
        pvp_pkg::SUB_PVAL: begin
          rd_val = pre_val[psel];
          rd_ok  = 1'b1;
          wr_ok  = ($signed(od_wdata_i) >= pvp_pkg::POS_MIN) && ($signed(od_wdata_i) <= pvp_pkg::POS_MAX);
        end
        pvp_pkg::SUB_PCMD: begin
          rd_val = {24'h0, pre_cmd[psel]};
          rd_ok  = 1'b1;
          wr_ok  = in_urange(od_wdata_i, 32'h0, pvp_pkg::PCMD_MAX);            // R8
        end
        default: rd_ok = 1'b0;
      endcase
    end else if (hit_rng) begin
      case (od_sub_i)
        pvp_pkg::SUB_REN: begin
          rd_val = {31'h0, rng_en[od_index_i[0]]};
          rd_ok  = 1'b1;
          wr_ok  = in_urange(od_wdata_i, 32'h0, pvp_pkg::BIT_MAX);
        end
        pvp_pkg::SUB_RLO, pvp_pkg::SUB_RHI: begin
          rd_val = (od_sub_i == pvp_pkg::SUB_RLO) ? rng_lo[od_index_i[0]] : rng_hi[od_index_i[0]];
          rd_ok  = 1'b1;
          wr_ok  = ($signed(od_wdata_i) >= pvp_pkg::POS_MIN) && ($signed(od_wdata_i) <= pvp_pkg::POS_MAX);
        end
        default: rd_ok = 1'b0;
      endcase
    end else if (hit_vel) begin
      case (od_sub_i)
        pvp_pkg::SUB_VRES: begin
          rd_val = {29'h0, vel_res};
          rd_ok  = 1'b1;
          wr_ok  = in_urange(od_wdata_i, pvp_pkg::VRES_MIN, pvp_pkg::VRES_MAX);  // R18
        end
        pvp_pkg::SUB_VWIN: begin
          rd_val = {29'h0, vel_win};
          rd_ok  = 1'b1;
          wr_ok  = in_urange(od_wdata_i, 32'h0, pvp_pkg::VWIN_MAX);
        end
        pvp_pkg::SUB_VFREE: begin
          rd_val = {16'h0, vel_free};
          rd_ok  = 1'b1;
          wr_ok  = in_urange(od_wdata_i, pvp_pkg::FREE_MIN, pvp_pkg::FREE_MAX); // R19
        end
        pvp_pkg::SUB_VVAL: begin
          rd_val = vel_o;
          rd_ok  = 1'b1;
          wr_ok  = 1'b0;                                                        // R20
        end
        default: rd_ok = 1'b0;
      endcase
    end else if (hit_vm) begin
      case (od_sub_i)
        pvp_pkg::SUB_VCFG: begin
          rd_val = {29'h0, vm_cfg[vsel]};
          rd_ok  = 1'b1;
          wr_ok  = in_urange(od_wdata_i, 32'h0, pvp_pkg::VCFG_MAX);
        end
        pvp_pkg::SUB_VLIM: begin
          rd_val = {16'h0, vm_lim[vsel]};
          rd_ok  = 1'b1;
          wr_ok  = in_urange(od_wdata_i, 32'h0, pvp_pkg::VLIM_MAX);
        end
        default: rd_ok = 1'b0;
      endcase
    end
  end

  logic wr_go;
  assign wr_go = od_wr_i && wr_ok;                                              // R23

  // access answer, one cycle after the request
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      od_ack_o   <= 1'b0;
      od_err_o   <= 1'b0;
      od_rdata_o <= 32'h0;
    end else begin
      od_ack_o   <= od_wr_i || od_rd_i;
      od_err_o   <= od_wr_i ? !wr_ok : (od_rd_i && !rd_ok);
      od_rdata_o <= (od_rd_i && !od_wr_i && rd_ok) ? rd_val : 32'h0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unit_inch <= 1'b0;                                                        // R14
      pos_res   <= pvp_pkg::RES_RST;
      dir_neg   <= 1'b0;
      offset    <= 32'sh0;
      pos_free  <= pvp_pkg::FREE_RST;
    end else if (wr_go && hit_pos) begin
      unit_inch <= (od_sub_i == pvp_pkg::SUB_UNIT) ? od_wdata_i[0] : unit_inch;
      pos_res   <= (od_sub_i == pvp_pkg::SUB_RES)  ? od_wdata_i[2:0] : pos_res;
      dir_neg   <= (od_sub_i == pvp_pkg::SUB_DIR)  ? od_wdata_i[0] : dir_neg;
      offset    <= (od_sub_i == pvp_pkg::SUB_OFFS) ? $signed(od_wdata_i) : offset; // R5
      pos_free  <= (od_sub_i == pvp_pkg::SUB_FREE) ? od_wdata_i[15:0] : pos_free;
    end
  end

  generate
    for (genvar p = 0; p < 2; p++) begin : g_pre
      logic sel;
      assign sel = wr_go && hit_pre && (psel == 1'(p));
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pre_val[p]  <= 32'sh0;
          pre_cmd[p]  <= 8'h0;
          pre_act[p]  <= 1'b0;
          pre_corr[p] <= 48'sh0;
        end else if (sel && od_sub_i == pvp_pkg::SUB_PVAL) begin
          pre_val[p] <= $signed(od_wdata_i);                                    // R10
        end else if (sel && od_sub_i == pvp_pkg::SUB_PCMD) begin
          pre_cmd[p] <= od_wdata_i[7:0];
          if (od_wdata_i[7:0] == pvp_pkg::PCMD_TEACH) begin
            pre_act[p]  <= 1'b1;                                                // R22
            pre_corr[p] <= 48'(pre_val[p]) * pvp_pkg::BASE_DIV - meas_eff;      // R22
          end else if (od_wdata_i[7:0] == pvp_pkg::PCMD_RESET) begin
            pre_act[p]  <= 1'b0;                                                // R9
          end
        end
      end
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          rng_en[p] <= 1'b0;
          rng_lo[p] <= 32'sh0;
          rng_hi[p] <= 32'sh0;
        end else if (wr_go && hit_rng && od_index_i[0] == 1'(p)) begin
          rng_en[p] <= (od_sub_i == pvp_pkg::SUB_REN) ? od_wdata_i[0] : rng_en[p];
          rng_lo[p] <= (od_sub_i == pvp_pkg::SUB_RLO) ? $signed(od_wdata_i) : rng_lo[p];
          rng_hi[p] <= (od_sub_i == pvp_pkg::SUB_RHI) ? $signed(od_wdata_i) : rng_hi[p];
        end
      end
    end
    for (genvar c = 0; c < pvp_pkg::VMON_CH; c++) begin : g_vmcfg
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          vm_cfg[c] <= 3'h0;
          vm_lim[c] <= 16'h0;
        end else if (wr_go && hit_vm && vsel == 2'(c)) begin
          vm_cfg[c] <= (od_sub_i == pvp_pkg::SUB_VCFG) ? od_wdata_i[2:0] : vm_cfg[c];
          vm_lim[c] <= (od_sub_i == pvp_pkg::SUB_VLIM) ? od_wdata_i[15:0] : vm_lim[c];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vel_res  <= pvp_pkg::VRES_RST;
      vel_win  <= pvp_pkg::VWIN_RST;
      vel_free <= pvp_pkg::FREE_RST;
    end else if (wr_go && hit_vel) begin
      vel_res  <= (od_sub_i == pvp_pkg::SUB_VRES)  ? od_wdata_i[2:0] : vel_res;
      vel_win  <= (od_sub_i == pvp_pkg::SUB_VWIN)  ? od_wdata_i[2:0] : vel_win;
      vel_free <= (od_sub_i == pvp_pkg::SUB_VFREE) ? od_wdata_i[15:0] : vel_free;
    end
  end

  // position output and range flags, updated per measurement
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_o       <= 32'sh0;
      pos_valid_o <= 1'b0;
      range_out_o <= 2'h0;
    end else begin
      pos_valid_o <= meas_valid_i;
      if (meas_valid_i) begin
        pos_o       <= clamp(pos_scaled);
        range_out_o <= rng_outside;
      end
    end
  end

  // window averaging; a sample landing on the window end opens the next one
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vsum        <= 48'sh0;
      vcnt        <= 24'h0;
      vtimer      <= 24'h0;
      vel_o       <= 32'sh0;
      vel_valid_o <= 1'b0;
      vmean_base  <= 48'sh0;
    end else begin
      vel_valid_o <= win_end;
      if (win_end) begin
        vtimer     <= win_len - 24'h1;
        vsum       <= meas_valid_i ? vsamp : 48'sh0;
        vcnt       <= meas_valid_i ? 24'h1 : 24'h0;
        vel_o      <= clamp(vsigned / vel_div(vel_res, vel_free));              // R18 R19 R20
        vmean_base <= vsigned / pvp_pkg::BASE_DIV;
      end else begin
        vtimer <= vtimer - 24'h1;
        if (meas_valid_i) begin
          vsum <= vsum + vsamp;
          vcnt <= vcnt + 24'h1;
        end
      end
    end
  end

endmodule : pvp_postproc
